// >>> src/dio_assign_regs.svh
`ifndef DIO_ASSIGN_REGS_SVH
`define DIO_ASSIGN_REGS_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define REG_IN_SEL0      8'h00
`define REG_OUT_SEL0     8'h18
`define REG_IN_NC        8'h30
`define REG_OUT_NC       8'h34
`define REG_TERM_STATE   8'h38
`define REG_IRQ_STATUS   8'h3c
`define REG_IRQ_MASK     8'h40
`define REG_NET_PERMIT   8'h44
`define REG_LAST         8'h44

// ****************************************************************
// function codes and reset values
// ****************************************************************
`define CODE_NONE        8'h00
`define CODE_PERMIT      8'h01
`define CODE_OVERLOAD    8'hce
`define CODE_INFO_LO     8'he0
`define CODE_INFO_HI     8'hff
`define IN_SEL0_RST      8'h1e
`define IN_SEL1_RST      8'h01
`define IN_SEL2_RST      8'h0c
`define IN_SEL3_RST      8'h68
`define IN_SEL4_RST      8'h1c
`define IN_SEL5_RST      8'h1d
`define OUT_SEL0_RST     8'h90
`define OUT_SEL1_RST     8'h89
`define OUT_SEL2_RST     8'h00
`define OUT_SEL3_RST     8'h8e
`define OUT_SEL4_RST     8'h86
`define OUT_SEL5_RST     8'h82

// ****************************************************************
// interrupt status bit positions
// ****************************************************************
`define IRQ_IN_CHANGE    0
`define IRQ_OUT_CHANGE   1
`define IRQ_OVERLOAD     2
`define IRQ_WIDTH        3

`endif

// >>> src/dio_assign_pkg.sv
`default_nettype none

package dio_assign_pkg;

  // one selector value: a function code
  typedef logic [7:0] func_code_type;

  // avalon-mm slave request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avm_req_type;

  // avalon-mm slave answer bundle
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
    logic [1:0]  response;
  } avm_rsp_type;

  // bus slave answer phase
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

endpackage

`default_nettype wire

// >>> src/output_selector.sv
`timescale 1ns/1ps
`default_nettype none

`include "dio_assign_regs.svh"

// picks one output function bit by its code, code 0 gives inactive
module output_selector
  import dio_assign_pkg::*;
(
  input  wire logic [255:0]  func_vec,
  input  wire func_code_type sel,
  output logic               value
);

  // ****************************************************************
  // selection
  // ****************************************************************
  always_comb begin
    if (sel == `CODE_NONE) begin
      value = 1'b0;
    end else begin
      value = func_vec[sel];
    end
  end

endmodule

`default_nettype wire

// >>> src/direct_io_signal_assignment.sv
// Behaviour
// - six input selectors with fixed defaults
// - six output selectors, code zero unassigned
// - output selectors reset to fixed codes
// - shared input function is OR of terminals
// - unassigned permit input stays on
// - permit on terminal and network: AND
// - code 206 follows overload torque reached
// - codes 224 to 255 follow info flags
// - normally-closed terminals invert logical polarity
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "dio_assign_regs.svh"

module direct_io_signal_assignment
  import dio_assign_pkg::*;
#(
  parameter int N_TERM = 6
)
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire avm_req_type   avm_req,
  output avm_rsp_type        avm_rsp,
  input  wire logic [5:0]    phys_input_terminal,
  output logic [5:0]         phys_output_terminal,
  output logic [255:0]       input_func,
  input  wire logic [255:0]  output_func_src,
  input  wire logic          overload_torque_reached,
  input  wire logic [31:0]   info_flags,
  input  wire logic          net_permit_assigned,
  input  wire logic          net_permit_on,
  output logic               irq
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (N_TERM != 6) begin : g_bad_term
    $error("terminal count must be six");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  func_code_type in_sel_r  [6];   // input terminal selectors
  func_code_type out_sel_r [6];   // output terminal selectors
  logic [5:0]    in_nc_r;         // input normally-closed flags
  logic [5:0]    out_nc_r;        // output normally-closed flags
  logic [5:0]    pin_s1_r;        // synchroniser first stage
  logic [5:0]    pin_s2_r;        // synchroniser second stage
  logic [5:0]    in_logic_r;      // logical state of inputs
  logic [5:0]    out_prev_r;      // last output logical state
  logic          ovl_prev_r;      // last overload level
  logic [`IRQ_WIDTH-1:0] irq_status_r;  // sticky events
  logic [`IRQ_WIDTH-1:0] irq_mask_r;    // interrupt enables
  bus_state_type bus_r;           // answer phase
  logic [31:0]   rdata_r;         // registered read data
  logic [1:0]    resp_r;          // registered response
  logic [255:0]  func_vec;        // output function vector
  logic [5:0]    out_logic;       // selected output logic
  logic [`IRQ_WIDTH-1:0] irq_event;     // event pulses
  logic          wr_ok;           // write accepted this edge
  logic          rd_ok;           // read accepted this edge

  // decode: index of a selector register, or 7 if none
  function automatic logic [2:0] sel_index(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    if (addr >= base && off < 8'h18 && off[1:0] == 2'b00) begin
      sel_index = off[4:2];
    end else begin
      sel_index = 3'd7;
    end
  endfunction

  // mapped offsets only
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) && (addr <= `REG_LAST);
  endfunction

  // ****************************************************************
  // input pin synchroniser
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
    end else begin
      pin_s1_r <= phys_input_terminal;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************************************
  // input polarity
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_logic_r <= 6'h00;
    end else begin
      in_logic_r <= pin_s2_r ^ in_nc_r;
    end
  end

  // ****************************************************************
  // input function routing
  // ****************************************************************
  always_comb begin
    logic permit_direct;
    logic permit_assigned;
    permit_direct   = 1'b0;
    permit_assigned = 1'b0;
    input_func      = '0;
    for (int i = 0; i < 6; i++) begin
      if (in_sel_r[i] != `CODE_NONE) begin
        input_func[in_sel_r[i]] = input_func[in_sel_r[i]] | in_logic_r[i];
      end
      if (in_sel_r[i] == `CODE_PERMIT) begin
        permit_assigned = 1'b1;
        permit_direct   = permit_direct | in_logic_r[i];
      end
    end
    if (!permit_assigned && !net_permit_assigned) begin
      input_func[`CODE_PERMIT] = 1'b1;
    end else if (permit_assigned && net_permit_assigned) begin
      input_func[`CODE_PERMIT] = permit_direct & net_permit_on;
    end else if (net_permit_assigned) begin
      input_func[`CODE_PERMIT] = net_permit_on;
    end else begin
      input_func[`CODE_PERMIT] = permit_direct;
    end
  end

  // ****************************************************************
  // output function vector
  // ****************************************************************
  always_comb begin
    func_vec = output_func_src;
    func_vec[`CODE_OVERLOAD] = overload_torque_reached;
    func_vec[`CODE_INFO_HI:`CODE_INFO_LO] = info_flags;
    func_vec[`CODE_NONE] = 1'b0;
  end

  for (genvar g = 0; g < 6; g++) begin : g_out
    output_selector u_sel (
      .func_vec (func_vec),
      .sel      (out_sel_r[g]),
      .value    (out_logic[g])
    );
  end

  // ****************************************************************
  // output terminals, registered
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      phys_output_terminal <= 6'h00;
      out_prev_r           <= 6'h00;
      ovl_prev_r           <= 1'b0;
    end else begin
      phys_output_terminal <= out_logic ^ out_nc_r;
      out_prev_r           <= out_logic;
      ovl_prev_r           <= overload_torque_reached;
    end
  end

  // events: any logical change, overload rising
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_IN_CHANGE]  = |(in_logic_r ^ (pin_s2_r ^ in_nc_r));
    irq_event[`IRQ_OUT_CHANGE] = |(out_prev_r ^ out_logic);
    irq_event[`IRQ_OVERLOAD]   = overload_torque_reached & ~ovl_prev_r;
  end

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait cycle; registered read data avoids a long mux path
  assign wr_ok = avm_req.write && bus_r == BUS_ACK;
  assign rd_ok = avm_req.read && bus_r == BUS_ACK;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_r <= BUS_IDLE;
    end else if (bus_r == BUS_ACK) begin
      bus_r <= BUS_IDLE;
    end else if (avm_req.read || avm_req.write) begin
      bus_r <= BUS_ACK;
    end
  end

  always_comb begin
    avm_rsp.waitrequest = (avm_req.read || avm_req.write) && bus_r == BUS_IDLE;
    avm_rsp.readdata    = rdata_r;
    avm_rsp.response    = resp_r;
  end

  // ****************************************************************
  // selector and polarity registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_sel_r[0]  <= `IN_SEL0_RST;
      in_sel_r[1]  <= `IN_SEL1_RST;
      in_sel_r[2]  <= `IN_SEL2_RST;
      in_sel_r[3]  <= `IN_SEL3_RST;
      in_sel_r[4]  <= `IN_SEL4_RST;
      in_sel_r[5]  <= `IN_SEL5_RST;
      out_sel_r[0] <= `OUT_SEL0_RST;
      out_sel_r[1] <= `OUT_SEL1_RST;
      out_sel_r[2] <= `OUT_SEL2_RST;
      out_sel_r[3] <= `OUT_SEL3_RST;
      out_sel_r[4] <= `OUT_SEL4_RST;
      out_sel_r[5] <= `OUT_SEL5_RST;
      in_nc_r      <= 6'h00;
      out_nc_r     <= 6'h00;
      irq_mask_r   <= '0;
    end else if (wr_ok && avm_req.byteenable[0]) begin
      if (sel_index(avm_req.address, `REG_IN_SEL0) != 3'd7) begin
        in_sel_r[sel_index(avm_req.address, `REG_IN_SEL0)] <= avm_req.writedata[7:0];
      end
      if (sel_index(avm_req.address, `REG_OUT_SEL0) != 3'd7) begin
        out_sel_r[sel_index(avm_req.address, `REG_OUT_SEL0)] <= avm_req.writedata[7:0];
      end
      if (avm_req.address == `REG_IN_NC) begin
        in_nc_r <= avm_req.writedata[5:0];
      end
      if (avm_req.address == `REG_OUT_NC) begin
        out_nc_r <= avm_req.writedata[5:0];
      end
      if (avm_req.address == `REG_IRQ_MASK) begin
        irq_mask_r <= avm_req.writedata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // sticky status, write one to clear, set wins
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_status_r <= '0;
    end else if (wr_ok && avm_req.byteenable[0] && avm_req.address == `REG_IRQ_STATUS) begin
      irq_status_r <= (irq_status_r & ~avm_req.writedata[`IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status_r <= irq_status_r | irq_event;
    end
  end

  // level interrupt from registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ****************************************************************
  // read data, captured during the wait cycle
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'b00;
    end else if ((avm_req.read || avm_req.write) && bus_r == BUS_IDLE) begin
      rdata_r <= 32'h0000_0000;
      // unmapped address answers slave error
      resp_r  <= mapped(avm_req.address) ? 2'b00 : 2'b10;
      if (avm_req.read) begin
        if (sel_index(avm_req.address, `REG_IN_SEL0) != 3'd7) begin
          rdata_r[7:0] <= in_sel_r[sel_index(avm_req.address, `REG_IN_SEL0)];
        end else if (sel_index(avm_req.address, `REG_OUT_SEL0) != 3'd7) begin
          rdata_r[7:0] <= out_sel_r[sel_index(avm_req.address, `REG_OUT_SEL0)];
        end else begin
          case (avm_req.address)
            `REG_IN_NC:      rdata_r[5:0] <= in_nc_r;
            `REG_OUT_NC:     rdata_r[5:0] <= out_nc_r;
            `REG_TERM_STATE: rdata_r[13:0] <= {input_func[`CODE_PERMIT], out_prev_r, 1'b0, in_logic_r};
            `REG_IRQ_STATUS: rdata_r[`IRQ_WIDTH-1:0] <= irq_status_r;
            `REG_IRQ_MASK:   rdata_r[`IRQ_WIDTH-1:0] <= irq_mask_r;
            `REG_NET_PERMIT: rdata_r[1:0] <= {net_permit_on, net_permit_assigned};
            default:         rdata_r <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> dv/dio_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// sensors and switches wired to the input terminals
// ****************************************************************
module dio_field_model (
  input  wire logic       mclk,
  input  wire logic [5:0] level_cmd,
  input  wire logic       slow,
  output logic [5:0]      in_pins
);
  logic [5:0] d1_r = 6'h00;  // first settling stage
  logic [5:0] d2_r = 6'h00;  // second settling stage
  // a slow contact settles two cycles late, so the sync chain sees late edges
  always_ff @(posedge mclk) begin
    d1_r <= level_cmd;
    d2_r <= d1_r;
  end
  assign in_pins = slow ? d2_r : level_cmd;
endmodule
`default_nettype wire

// >>> dv/dio_assign_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_assign_regs.svh"
// ****************************************************************
// bus, reset and permit checks
// ****************************************************************
module dio_assign_props
  import dio_assign_pkg::*;
#(
  parameter int N_TERM = 6
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire avm_req_type       avm_req,
  input  wire avm_rsp_type       avm_rsp,
  input  wire logic [N_TERM-1:0] phys_output_terminal,
  input  wire logic [255:0]      input_func,
  input  wire logic              net_permit_assigned,
  input  wire logic              net_permit_on,
  input  wire logic              irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic req = avm_req.read | avm_req.write;    // any request
  wire logic unmap = (avm_req.address > `REG_LAST) || (avm_req.address[1:0] != 2'b00);  // off the word map
  // held off once, then answered
  sequence s_hold_answer;
    avm_rsp.waitrequest ##1 !avm_rsp.waitrequest;
  endsequence
  // completing edge of a transfer
  sequence s_done;
    req && !avm_rsp.waitrequest;
  endsequence
  a_wait_first: assert property ($rose(req) |-> s_hold_answer)
    else $error("request not answered in its second cycle");
  a_unmapped_error: assert property (s_done ##0 unmap |-> avm_rsp.response == 2'b10)
    else $error("unmapped access without error");
  a_unmapped_zero: assert property (s_done ##0 (unmap && avm_req.read) |-> avm_rsp.readdata == 32'h0)
    else $error("unmapped read data not zero");
  a_mapped_okay: assert property (s_done ##0 !unmap |-> avm_rsp.response == 2'b00)
    else $error("mapped access flagged as error");
  a_rdata_stands: assert property (!req ##1 !req |-> $stable(avm_rsp.readdata))
    else $error("read data moved while idle");
  // with the network side off the permit can never be on
  a_permit_net_off: assert property ((net_permit_assigned && !net_permit_on)[*5] |-> !input_func[`CODE_PERMIT])
    else $error("permit on while network side off");
  a_irq_reset: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("interrupt high after reset");
  a_pins_reset: assert property (disable iff (1'b0) rst |=> phys_output_terminal == 6'h00)
    else $error("output pins active after reset");
endmodule
`default_nettype wire

// >>> dv/direct_io_signal_assignment_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_assign_regs.svh"
// ****************************************************************
// self-checking bench
// ****************************************************************
module direct_io_signal_assignment_test
  import dio_assign_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  avm_req_type  avm_req = '0;
  avm_rsp_type  avm_rsp;
  logic [5:0]   pin_cmd = 6'h00;  // wanted sensor states
  logic         slow = 1'b0;      // sensors settle late
  logic [5:0]   in_pins;
  logic [5:0]   out_pins;
  logic [255:0] ifunc;
  logic [255:0] src = '0;
  logic         ovl = 1'b0;
  logic [31:0]  info = 32'h0;
  logic         net_asg = 1'b0;
  logic         net_on = 1'b0;
  logic         irq;
  logic [63:0]  expq[$];          // mask and value of each read
  logic [63:0]  e;
  logic [7:0]   c;
  logic         x;
  int           n_fail = 0;
  int           n_checks = 0;
  logic [7:0]   dflt [12] = '{8'h1e, 8'h01, 8'h0c, 8'h68, 8'h1c, 8'h1d,
                              8'h90, 8'h89, 8'h00, 8'h8e, 8'h86, 8'h82};
  always #5 mclk = ~mclk;
  direct_io_signal_assignment #(.N_TERM(6)) dut (
    .mclk(mclk), .rst(rst), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .phys_input_terminal(in_pins), .phys_output_terminal(out_pins), .input_func(ifunc),
    .output_func_src(src), .overload_torque_reached(ovl), .info_flags(info),
    .net_permit_assigned(net_asg), .net_permit_on(net_on), .irq(irq));
  dio_field_model field (.mclk(mclk), .level_cmd(pin_cmd), .slow(slow), .in_pins(in_pins));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; held until waitrequest is seen low, then released for a cycle
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    avm_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hf};
    if (rd) expq.push_back({m, d & m});
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (avm_rsp.waitrequest !== 1'b0);
    avm_req <= '0;
    @(posedge mclk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic print_verdict();
    // a read that never completed leaves its note behind
    if (expq.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read results are matched against the oldest note
  always @(posedge mclk) begin
    if (avm_req.read && avm_rsp.waitrequest === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      check(avm_rsp.readdata & e[63:32], e[31:0]);
    end
  end
  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    settle(20000);
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h7eaa10d0));
    settle(5);
    rst <= 1'b0;
    settle(1);
    for (int i = 0; i < 12; i++) bus(1'b1, 8'(i * 4), 32'(dflt[i]), 32'hff);
    bus(1'b1, `REG_IN_NC, 32'h0, 32'h3f);
    bus(1'b0, 8'h48, 32'hff, 32'h0);
    bus(1'b1, 8'h48, 32'h0, 32'hffffffff);
    $display("test defaults done");
    // codes 0, 206, info range and plain codes on terminal 0
    for (int k = 0; k < 8; k++) begin
      c = (k == 0) ? 8'h00 : (k == 1) ? 8'hce : (k < 5) ? 8'he0 + 8'($urandom_range(31)) : 8'($urandom_range(205, 1));
      for (int j = 0; j < 8; j++) src[j*32 +: 32] <= $urandom;
      ovl <= 1'($urandom);
      info <= $urandom;
      slow <= 1'($urandom);
      bus(1'b0, `REG_OUT_SEL0, {24'h0, c}, 32'h0);
      settle(3);
      x = (c == 8'h00) ? 1'b0 : (c == 8'hce) ? ovl : (c >= 8'he0) ? info[c - 8'he0] : src[c];
      check(32'(out_pins[0]), 32'(x));
      check(32'(out_pins[5:1]), 32'({src[dflt[11]], src[dflt[10]], src[dflt[9]], 1'b0, src[dflt[7]]}));
    end
    bus(1'b0, `REG_OUT_NC, 32'h1, 32'h0);
    settle(3);
    check(32'(out_pins[0]), 32'(!x));
    bus(1'b0, `REG_OUT_NC, 32'h0, 32'h0);
    $display("test output routing done");
    // function 50 on terminals 0 and 2
    bus(1'b0, `REG_IN_SEL0, 32'h32, 32'h0);
    bus(1'b0, `REG_IN_SEL0 + 8'h08, 32'h32, 32'h0);
    for (int p = 0; p < 4; p++) begin
      pin_cmd <= {3'b000, 1'(p >> 1), 1'b0, 1'(p)};
      settle(8);
      check(32'(ifunc[50]), 32'(p != 0));
    end
    bus(1'b0, `REG_IN_NC, 32'h1, 32'h0);
    pin_cmd <= 6'h00;
    settle(8);
    check(32'(ifunc[50]), 32'h1);
    pin_cmd <= 6'h01;
    settle(8);
    check(32'(ifunc[50]), 32'h0);
    bus(1'b0, `REG_IN_NC, 32'h0, 32'h0);
    $display("test input merge done");
    // permit on terminal 1 and on the network
    net_asg <= 1'b1;
    for (int q = 0; q < 4; q++) begin
      pin_cmd <= {4'h0, 1'(q), 1'b0};
      net_on <= 1'(q >> 1);
      settle(8);
      check(32'(ifunc[1]), 32'(q == 3));
    end
    bus(1'b0, `REG_IN_SEL0 + 8'h04, 32'h02, 32'h0);
    net_asg <= 1'b0;
    net_on <= 1'b0;
    settle(8);
    check(32'(ifunc[1]), 32'h1);
    $display("test permit done");
    // interrupt: raise, mask, clear
    bus(1'b0, `REG_IRQ_MASK, 32'h7, 32'h0);
    bus(1'b0, `REG_IRQ_STATUS, 32'h7, 32'h0);
    settle(2);
    check(32'(irq), 32'h0);
    pin_cmd <= 6'h08;
    settle(8);
    check(32'(irq), 32'h1);
    bus(1'b1, `REG_IRQ_STATUS, 32'h1, 32'h1);
    bus(1'b0, `REG_IRQ_MASK, 32'h0, 32'h0);
    settle(2);
    check(32'(irq), 32'h0);
    bus(1'b0, `REG_IRQ_STATUS, 32'h7, 32'h0);
    bus(1'b0, `REG_IRQ_MASK, 32'h7, 32'h0);
    settle(2);
    check(32'(irq), 32'h0);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
bind direct_io_signal_assignment dio_assign_props #(.N_TERM(N_TERM)) props (
  .mclk(mclk), .rst(rst), .avm_req(avm_req), .avm_rsp(avm_rsp),
  .phys_output_terminal(phys_output_terminal), .input_func(input_func),
  .net_permit_assigned(net_permit_assigned), .net_permit_on(net_permit_on), .irq(irq));
`default_nettype wire
